// *** rtl/bcr_pkg.sv ***
// Constants, field layouts and carrier types of the buck control registers.
// Assumes a 100 MHz clock and 8-bit registers on a 32-bit Avalon-MM bus.
package bcr_pkg;

  // Register indices; the byte address is four times the index
  localparam logic [5:0] IDX_B1_DISCHARGE = 6'h35;
  localparam logic [5:0] IDX_B1_LIMIT     = 6'h36;
  localparam logic [5:0] IDX_B2_MODE      = 6'h37;
  localparam logic [5:0] IDX_B2_RUN       = 6'h38;
  localparam logic [5:0] IDX_B2_STBY      = 6'h39;
  localparam logic [5:0] IDX_B2_SLP       = 6'h3a;

  // Field positions and read masks
  localparam int B1_DIS_BIT    = 7;
  localparam int B1_TOFF_BIT   = 4;
  localparam int M_RUN_EN      = 0;
  localparam int M_STBY_EN     = 1;
  localparam int M_SLP_EN      = 2;
  localparam int M_LPWR        = 3;
  localparam int M_RAMP_SLOW   = 4;
  localparam int M_FCCM_DOWN   = 5;
  localparam int M_FIXED_PULSE = 6;
  localparam logic [7:0] B1_DIS_MASK   = 8'h80;
  localparam logic [7:0] B1_LIM_MASK   = 8'h13;
  localparam logic [7:0] B2_MODE_MASK  = 8'h7f;
  localparam logic [7:0] B2_VOLT_MASK  = 8'h3f;

  // Ramp step times
  localparam int CLK_NS       = 10;
  localparam int RAMP_FAST_NS = 2000;
  localparam int RAMP_SLOW_NS = 4000;
  localparam logic [8:0] RAMP_FAST_CYC = 9'(RAMP_FAST_NS / CLK_NS);
  localparam logic [8:0] RAMP_SLOW_CYC = 9'(RAMP_SLOW_NS / CLK_NS);

  typedef enum logic [1:0] {
    PM_RUN   = 2'b00,
    PM_STBY  = 2'b01,
    PM_SLEEP = 2'b11
  } bcr_pmode_e;

  typedef enum logic [1:0] {
    RAMP_IDLE = 2'b00,
    RAMP_UP   = 2'b01,
    RAMP_DOWN = 2'b11
  } bcr_ramp_e;

  typedef struct packed {
    logic       b1_discharge_disable;
    logic [1:0] b1_current_limit_sel;
    logic [5:0] b2_vcode;
    logic       b2_run_enable;
    logic       b2_ramp_slow;
    logic       b2_fuse_ramp_select;
  } bcr_fuse_s;

  typedef struct packed {
    logic       discharge_on;
    logic [3:0] current_limit;
    logic       toff_sel;
  } bcr_b1_drv_s;

  typedef struct packed {
    logic       enable;
    logic [5:0] vcode;
    logic       low_power;
    logic       fixed_pulse;
    logic       forced_conduction;
  } bcr_b2_drv_s;

  typedef struct packed {
    logic        loaded;
    logic        rvalid;
    logic [7:0]  rdata;
    logic [7:0]  b1_ctrl;
    logic [7:0]  b1_lim;
    logic [5:0]  b2_run;
    logic [5:0]  b2_stby;
    logic [5:0]  b2_slp;
    logic [6:0]  b2_mode;
    logic        fuse_ramp_sel;
    bcr_ramp_e   ramp;
    logic [8:0]  tick;
    logic [5:0]  vcode;
    bcr_b1_drv_s b1;
    bcr_b2_drv_s b2;
  } bcr_state_s;

  localparam bcr_state_s STATE_RESET = '0;

endpackage

// *** rtl/bcr_regs.sv ***
// Control registers of two buck regulators and their drive to the analog side.
// Assumes fuse values and power mode are steady and synchronous to ref_clk.
//
// Notes on behaviour
// - Discharge resistor on while buck 1 off, unless bit 7 disables it.
// - Two-bit current limit code decodes into four levels, lowest at 00.
// - Buck 2 run code: six bits, every code accepted, bits 7:6 unused.
// - Separate standby voltage code; power-on value equals the run code.
// - Separate sleep voltage code; power-on value equals the run code.
// - Run enable loads from fuses; software may clear it to stop buck 2 in run mode.
// - Bit 1 enables buck 2 in standby; defaults to the fused run enable.
// - Bit 2 enables buck 2 in sleep; reset value is zero.
// - Bit 3 puts buck 2 into low power during standby or sleep.
// - Bit 4 picks ramp 2 us or 4 us per step; fuse select overrides it.
// - Bit 5 forces continuous conduction while the voltage ramps down.
// - Bit 6 forces fixed pulse-width operation regardless of load.
// - Fuse-loaded fields take fuse values at power-on, stay read/write.
// - Asynchronous-set fields are set by an event and stay read/write.
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ns

module bcr_regs (
  input  wire logic                ref_clk,
  input  wire logic                reset,
  input  wire logic                ce,
  input  wire logic [7:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  input  wire logic [3:0]          byteenable,
  output logic [31:0]              readdata,
  output logic                     waitrequest,
  input  wire bcr_pkg::bcr_fuse_s  fuse,
  input  wire bcr_pkg::bcr_pmode_e power_mode,
  input  wire logic                buck1_on,
  input  wire logic                sleep_enable_set,
  output bcr_pkg::bcr_b1_drv_s     buck1_drive,
  output bcr_pkg::bcr_b2_drv_s     buck2_drive
);

  bcr_pkg::bcr_state_s s;
  bcr_pkg::bcr_state_s next_s;
  logic [5:0]          target;
  logic                mode_en;
  logic [8:0]          period;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic hit(input logic [7:0] a, input logic [5:0] idx);
    return a[7:2] == idx;
  endfunction

  function automatic logic [7:0] merge(input logic [7:0] old_v,
                                       input logic [7:0] wd,
                                       input logic [7:0] mask);
    return (old_v & ~mask) | (wd & mask);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: reads take one extra cycle, writes none

  assign waitrequest = !ce || !s.loaded || (read && !s.rvalid);
  assign readdata    = {24'h000000, s.rdata};
  assign buck1_drive = s.b1;
  assign buck2_drive = s.b2;

  ////////////////////////////////////////////////////////////////////////////
  // Mode selection of target code and enable

  always_comb begin
    unique case (power_mode)
      bcr_pkg::PM_RUN: begin
        target  = s.b2_run;
        mode_en = s.b2_mode[bcr_pkg::M_RUN_EN];
      end
      bcr_pkg::PM_STBY: begin
        target  = s.b2_stby;
        mode_en = s.b2_mode[bcr_pkg::M_STBY_EN];
      end
      default: begin
        target  = s.b2_slp;
        mode_en = s.b2_mode[bcr_pkg::M_SLP_EN];
      end
    endcase
    if (s.fuse_ramp_sel || !s.b2_mode[bcr_pkg::M_RAMP_SLOW]) begin
      period = bcr_pkg::RAMP_FAST_CYC;
    end else begin
      period = bcr_pkg::RAMP_SLOW_CYC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [7:0] wd;
    wd     = writedata[7:0];
    next_s = s;
    if (ce) begin
      next_s.rvalid = 1'b0;
      if (!s.loaded) begin
        next_s.loaded  = 1'b1;
        next_s.b1_ctrl = {fuse.b1_discharge_disable, 7'h00};
        next_s.b1_lim  = {6'h00, fuse.b1_current_limit_sel};
        next_s.b2_run  = fuse.b2_vcode;
        next_s.b2_stby = fuse.b2_vcode;
        next_s.b2_slp  = fuse.b2_vcode;
        next_s.vcode   = fuse.b2_vcode;
        next_s.b2_mode[bcr_pkg::M_RUN_EN]    = fuse.b2_run_enable;
        next_s.b2_mode[bcr_pkg::M_STBY_EN]   = fuse.b2_run_enable;
        next_s.b2_mode[bcr_pkg::M_RAMP_SLOW] = fuse.b2_ramp_slow;
        next_s.fuse_ramp_sel = fuse.b2_fuse_ramp_select;
      end else begin
        if (read && !s.rvalid) begin
          next_s.rvalid = 1'b1;
          next_s.rdata  = 8'h00;
          if (hit(address, bcr_pkg::IDX_B1_DISCHARGE)) begin
            next_s.rdata = s.b1_ctrl & bcr_pkg::B1_DIS_MASK;
          end
          if (hit(address, bcr_pkg::IDX_B1_LIMIT)) begin
            next_s.rdata = s.b1_lim & bcr_pkg::B1_LIM_MASK;
          end
          if (hit(address, bcr_pkg::IDX_B2_MODE)) begin
            next_s.rdata = {1'b0, s.b2_mode};
          end
          if (hit(address, bcr_pkg::IDX_B2_RUN)) begin
            next_s.rdata = {2'b00, s.b2_run};
          end
          if (hit(address, bcr_pkg::IDX_B2_STBY)) begin
            next_s.rdata = {2'b00, s.b2_stby};
          end
          if (hit(address, bcr_pkg::IDX_B2_SLP)) begin
            next_s.rdata = {2'b00, s.b2_slp};
          end
        end
        if (write && byteenable[0]) begin
          if (hit(address, bcr_pkg::IDX_B1_DISCHARGE)) begin
            next_s.b1_ctrl = merge(s.b1_ctrl, wd, bcr_pkg::B1_DIS_MASK);
          end
          if (hit(address, bcr_pkg::IDX_B1_LIMIT)) begin
            next_s.b1_lim = merge(s.b1_lim, wd, bcr_pkg::B1_LIM_MASK);
          end
          if (hit(address, bcr_pkg::IDX_B2_MODE)) begin
            next_s.b2_mode = wd[6:0];
          end
          if (hit(address, bcr_pkg::IDX_B2_RUN)) begin
            next_s.b2_run = wd[5:0];
          end
          if (hit(address, bcr_pkg::IDX_B2_STBY)) begin
            next_s.b2_stby = wd[5:0];
          end
          if (hit(address, bcr_pkg::IDX_B2_SLP)) begin
            next_s.b2_slp = wd[5:0];
          end
        end
        // Set event wins over a clearing write in the same cycle
        if (sleep_enable_set) begin
          next_s.b2_mode[bcr_pkg::M_SLP_EN] = 1'b1;
        end
        // One code step per period toward the active target
        unique case (s.ramp)
          bcr_pkg::RAMP_IDLE: begin
            next_s.tick = period - 9'h001;
            if (target > s.vcode) begin
              next_s.ramp = bcr_pkg::RAMP_UP;
            end else if (target < s.vcode) begin
              next_s.ramp = bcr_pkg::RAMP_DOWN;
            end
          end
          bcr_pkg::RAMP_UP, bcr_pkg::RAMP_DOWN: begin
            if (s.tick != 9'h000) begin
              next_s.tick = s.tick - 9'h001;
            end else begin
              next_s.tick = period - 9'h001;
              if (target > s.vcode) begin
                next_s.vcode = s.vcode + 6'h01;
              end else if (target < s.vcode) begin
                next_s.vcode = s.vcode - 6'h01;
              end
              if (target == s.vcode) begin
                next_s.ramp = bcr_pkg::RAMP_IDLE;
              end
            end
          end
          default: begin
            next_s.ramp = bcr_pkg::RAMP_IDLE;
          end
        endcase
      end
      // Analog drive, registered from current register contents
      next_s.b1.discharge_on = !s.b1_ctrl[bcr_pkg::B1_DIS_BIT]
                               && !buck1_on;
      next_s.b1.current_limit = 4'h1 << s.b1_lim[1:0];
      next_s.b1.toff_sel = s.b1_lim[bcr_pkg::B1_TOFF_BIT];
      next_s.b2.enable = s.loaded && mode_en;
      next_s.b2.vcode = s.vcode;
      next_s.b2.low_power = s.b2_mode[bcr_pkg::M_LPWR]
                            && power_mode != bcr_pkg::PM_RUN;
      next_s.b2.fixed_pulse = s.b2_mode[bcr_pkg::M_FIXED_PULSE];
      // Downward scaling is pending whenever the target lies below the code
      next_s.b2.forced_conduction = s.b2_mode[bcr_pkg::M_FCCM_DOWN]
                                    && target < s.vcode;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s <= bcr_pkg::STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence wr_run_s;
    ce && write && !waitrequest && byteenable[0]
    && hit(address, bcr_pkg::IDX_B2_RUN);
  endsequence

  sequence rd_run_s;
    ce && read && !waitrequest && hit(address, bcr_pkg::IDX_B2_RUN);
  endsequence

  discharge_drive_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce |=> buck1_drive.discharge_on
           == $past(!s.b1_ctrl[bcr_pkg::B1_DIS_BIT] && !buck1_on))
    else $error("discharge drive wrong");

  limit_decode_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce |=> buck1_drive.current_limit == (4'h1 << $past(s.b1_lim[1:0])))
    else $error("current limit decode wrong");

  run_code_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    rd_run_s |-> s.rdata == {2'b00, s.b2_run})
    else $error("run code readback wrong");

  run_write_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    wr_run_s |=> s.b2_run == $past(writedata[5:0]))
    else $error("run code write lost");

  stby_write_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && write && !waitrequest && byteenable[0]
    && hit(address, bcr_pkg::IDX_B2_STBY)
    |=> s.b2_stby == $past(writedata[5:0]))
    else $error("standby code write lost");

  slp_write_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && write && !waitrequest && byteenable[0]
    && hit(address, bcr_pkg::IDX_B2_SLP)
    |=> s.b2_slp == $past(writedata[5:0]))
    else $error("sleep code write lost");

  fuse_copy_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    $rose(s.loaded) |-> s.b2_stby == s.b2_run && s.b2_slp == s.b2_run
      && s.b2_mode[bcr_pkg::M_STBY_EN] == s.b2_mode[bcr_pkg::M_RUN_EN])
    else $error("fuse load defaults wrong");

  run_enable_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && s.loaded && power_mode == bcr_pkg::PM_RUN
    |=> buck2_drive.enable == $past(s.b2_mode[bcr_pkg::M_RUN_EN]))
    else $error("run enable not applied");

  sleep_reset_a: assert property (
    @(posedge ref_clk)
    reset && !sleep_enable_set |=> !s.b2_mode[bcr_pkg::M_SLP_EN])
    else $error("sleep enable not cleared by reset");

  low_power_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce |=> buck2_drive.low_power == $past(s.b2_mode[bcr_pkg::M_LPWR]
                                   && power_mode != bcr_pkg::PM_RUN))
    else $error("low power drive wrong");

  ramp_step_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    s.loaded && $changed(s.vcode) |-> $past(s.tick) == 9'h000)
    else $error("voltage stepped off period");

  fccm_down_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce |=> buck2_drive.forced_conduction
           == $past(s.b2_mode[bcr_pkg::M_FCCM_DOWN]
                    && target < s.vcode))
    else $error("forced conduction wrong");

  fixed_pulse_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce |=> buck2_drive.fixed_pulse
           == $past(s.b2_mode[bcr_pkg::M_FIXED_PULSE]))
    else $error("fixed pulse drive wrong");

  async_set_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && s.loaded && sleep_enable_set
    |=> s.b2_mode[bcr_pkg::M_SLP_EN])
    else $error("sleep enable set lost");

  mode_select_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && s.loaded && s.ramp == bcr_pkg::RAMP_IDLE && target == s.vcode
    |=> buck2_drive.vcode == $past(target))
    else $error("mode voltage not applied");

  stby_enable_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && s.loaded && power_mode == bcr_pkg::PM_STBY
    |=> buck2_drive.enable == $past(s.b2_mode[bcr_pkg::M_STBY_EN]))
    else $error("standby enable not applied");

  sleep_enable_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && s.loaded && power_mode == bcr_pkg::PM_SLEEP
    |=> buck2_drive.enable == $past(s.b2_mode[bcr_pkg::M_SLP_EN]))
    else $error("sleep enable not applied");

  read_answer_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    ce && s.loaded && read && waitrequest ##1 ce && read
    |-> !waitrequest)
    else $error("read not answered after one wait state");

  ce_freeze_a: assert property (
    @(posedge ref_clk) disable iff (reset)
    !ce |=> $stable(s))
    else $error("state moved while clock enable low");

endmodule

// *** testbench/tb_bcr_regs.sv ***
// Self-checking bench for the buck regulator control register bank.
// Assumes rtl/bcr_pkg.sv and rtl/bcr_regs.sv are compiled before it.
`timescale 1ns/1ns

module tb_bcr_regs;
  logic                  ref_clk          = 1'b0;
  logic                  reset            = 1'b1;
  logic                  ce               = 1'b1;
  logic [7:0]            address          = 8'h00;
  logic                  read             = 1'b0;
  logic                  write            = 1'b0;
  logic [31:0]           writedata        = 32'h0;
  logic [3:0]            byteenable       = 4'h0;
  logic [31:0]           readdata;
  logic                  waitrequest;
  bcr_pkg::bcr_fuse_s    fuse             = {1'b1, 2'b10, 6'h15, 3'b100};
  bcr_pkg::bcr_pmode_e   power_mode       = bcr_pkg::PM_RUN;
  logic                  buck1_on         = 1'b0;
  logic                  sleep_enable_set = 1'b0;
  bcr_pkg::bcr_b1_drv_s  buck1_drive;
  bcr_pkg::bcr_b2_drv_s  buck2_drive;
  int                    err_count        = 0;
  int                    samples_checked  = 0;
  int                    cycles           = 0;

  bcr_regs i_dut (
    .ref_clk          (ref_clk),
    .reset            (reset),
    .ce               (ce),
    .address          (address),
    .read             (read),
    .write            (write),
    .writedata        (writedata),
    .byteenable       (byteenable),
    .readdata         (readdata),
    .waitrequest      (waitrequest),
    .fuse             (fuse),
    .power_mode       (power_mode),
    .buck1_on         (buck1_on),
    .sleep_enable_set (sleep_enable_set),
    .buck1_drive      (buck1_drive),
    .buck2_drive      (buck2_drive)
  );

  always #5 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Cycle ceiling well above the longest ramp wait
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_count++;
      wrap_up();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // The request stands until the rising edge that samples waitrequest low;
  // read data is taken at that same edge
  task automatic bus_xfer(input logic wr, input logic [5:0] idx,
                          input logic [7:0] wd, input logic [3:0] be,
                          output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk);
    address    <= {idx, 2'b00};
    writedata  <= {24'h0, wd};
    byteenable <= be;
    write      <= wr;
    read       <= !wr;
    do begin
      @(posedge ref_clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    if (n >= 50) chk(32'(waitrequest), 32'h0);
    write <= 1'b0;
    read  <= 1'b0;
  endtask

  task automatic wr_reg(input logic [5:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    bus_xfer(1'b1, idx, wd, 4'h1, d);
  endtask

  task automatic rd_chk(input logic [5:0] idx, input logic [7:0] exp);
    logic [31:0] d;
    bus_xfer(1'b0, idx, 8'h00, 4'h0, d);
    chk(d, {24'h0, exp});
  endtask

  task automatic settle();
    repeat (2) @(negedge ref_clk);
  endtask

  task automatic set_mode(input bcr_pkg::bcr_pmode_e m);
    @(posedge ref_clk);
    power_mode <= m;
    settle();
  endtask

  task automatic wait_code(input logic [5:0] code, output int n);
    n = 0;
    while (buck2_drive.vcode !== code && n < 15000) begin
      @(negedge ref_clk);
      n++;
    end
    chk(32'(buck2_drive.vcode), 32'(code));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_fuse_defaults();
    rd_chk(bcr_pkg::IDX_B1_DISCHARGE, 8'h80);
    rd_chk(bcr_pkg::IDX_B1_LIMIT, 8'h02);
    rd_chk(bcr_pkg::IDX_B2_RUN, 8'h15);
    rd_chk(bcr_pkg::IDX_B2_STBY, 8'h15);
    rd_chk(bcr_pkg::IDX_B2_SLP, 8'h15);
    rd_chk(bcr_pkg::IDX_B2_MODE, 8'h03);
    chk(32'(buck2_drive.enable), 32'h1);
    rd_chk(6'h3b, 8'h00);
    $display("Test fuse_defaults done");
  endtask

  task automatic t_voltage_codes();
    logic [31:0] d;
    wr_reg(bcr_pkg::IDX_B2_RUN, 8'hff);
    rd_chk(bcr_pkg::IDX_B2_RUN, 8'h3f);
    wr_reg(bcr_pkg::IDX_B2_RUN, 8'h00);
    rd_chk(bcr_pkg::IDX_B2_RUN, 8'h00);
    wr_reg(bcr_pkg::IDX_B2_STBY, 8'h2a);
    wr_reg(bcr_pkg::IDX_B2_SLP, 8'h3f);
    rd_chk(bcr_pkg::IDX_B2_STBY, 8'h2a);
    rd_chk(bcr_pkg::IDX_B2_SLP, 8'h3f);
    bus_xfer(1'b1, bcr_pkg::IDX_B2_RUN, 8'h3f, 4'h0, d);
    rd_chk(bcr_pkg::IDX_B2_RUN, 8'h00);
    wr_reg(6'h3b, 8'h55);
    rd_chk(6'h3b, 8'h00);
    $display("Test voltage_codes done");
  endtask

  task automatic t_limit_decode();
    for (int c = 0; c < 4; c++) begin
      wr_reg(bcr_pkg::IDX_B1_LIMIT, 8'(c));
      settle();
      chk(32'(buck1_drive.current_limit), 32'(1 << c));
    end
    wr_reg(bcr_pkg::IDX_B1_LIMIT, 8'hff);
    rd_chk(bcr_pkg::IDX_B1_LIMIT, 8'h13);
    settle();
    chk(32'(buck1_drive.current_limit), 32'h8);
    chk(32'(buck1_drive.toff_sel), 32'h1);
    $display("Test limit_decode done");
  endtask

  task automatic t_discharge();
    wr_reg(bcr_pkg::IDX_B1_DISCHARGE, 8'h00);
    settle();
    chk(32'(buck1_drive.discharge_on), 32'h1);
    wr_reg(bcr_pkg::IDX_B1_DISCHARGE, 8'h80);
    settle();
    chk(32'(buck1_drive.discharge_on), 32'h0);
    wr_reg(bcr_pkg::IDX_B1_DISCHARGE, 8'h00);
    @(posedge ref_clk);
    buck1_on <= 1'b1;
    settle();
    chk(32'(buck1_drive.discharge_on), 32'h0);
    $display("Test discharge done");
  endtask

  task automatic t_modes();
    wr_reg(bcr_pkg::IDX_B2_MODE, 8'h41);
    settle();
    chk(32'(buck2_drive.enable), 32'h1);
    chk(32'(buck2_drive.fixed_pulse), 32'h1);
    wr_reg(bcr_pkg::IDX_B2_MODE, 8'h00);
    settle();
    chk(32'(buck2_drive.enable), 32'h0);
    chk(32'(buck2_drive.fixed_pulse), 32'h0);
    wr_reg(bcr_pkg::IDX_B2_MODE, 8'h0a);
    set_mode(bcr_pkg::PM_STBY);
    chk(32'(buck2_drive.enable), 32'h1);
    chk(32'(buck2_drive.low_power), 32'h1);
    set_mode(bcr_pkg::PM_SLEEP);
    chk(32'(buck2_drive.enable), 32'h0);
    @(posedge ref_clk);
    sleep_enable_set <= 1'b1;
    @(posedge ref_clk);
    sleep_enable_set <= 1'b0;
    settle();
    chk(32'(buck2_drive.enable), 32'h1);
    rd_chk(bcr_pkg::IDX_B2_MODE, 8'h0e);
    wr_reg(bcr_pkg::IDX_B2_MODE, 8'h0a);
    rd_chk(bcr_pkg::IDX_B2_MODE, 8'h0a);
    set_mode(bcr_pkg::PM_RUN);
    chk(32'(buck2_drive.low_power), 32'h0);
    $display("Test modes done");
  endtask

  task automatic t_ramp();
    int n;
    wr_reg(bcr_pkg::IDX_B2_RUN, 8'h04);
    wr_reg(bcr_pkg::IDX_B2_STBY, 8'h06);
    wr_reg(bcr_pkg::IDX_B2_MODE, 8'h23);
    wait_code(6'h04, n);
    // Let the ramp fall idle so that the next step starts a full period
    repeat (210) @(negedge ref_clk);
    set_mode(bcr_pkg::PM_STBY);
    wait_code(6'h06, n);
    chk(32'(n >= 380 && n <= 420), 32'h1);
    repeat (210) @(negedge ref_clk);
    wr_reg(bcr_pkg::IDX_B2_MODE, 8'h33);
    set_mode(bcr_pkg::PM_RUN);
    repeat (10) @(negedge ref_clk);
    chk(32'(buck2_drive.forced_conduction), 32'h1);
    wait_code(6'h04, n);
    chk(32'(n >= 770 && n <= 820), 32'h1);
    settle();
    chk(32'(buck2_drive.forced_conduction), 32'h0);
    $display("Test ramp done");
  endtask

  task automatic t_clock_enable();
    @(posedge ref_clk);
    ce               <= 1'b0;
    sleep_enable_set <= 1'b1;
    settle();
    chk(32'(waitrequest), 32'h1);
    @(posedge ref_clk);
    ce               <= 1'b1;
    sleep_enable_set <= 1'b0;
    rd_chk(bcr_pkg::IDX_B2_MODE, 8'h33);
    $display("Test clock_enable done");
  endtask

  task automatic t_fuse_override();
    int n;
    @(posedge ref_clk);
    fuse  <= {1'b0, 2'b01, 6'h08, 3'b111};
    reset <= 1'b1;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    rd_chk(bcr_pkg::IDX_B2_MODE, 8'h13);
    rd_chk(bcr_pkg::IDX_B1_DISCHARGE, 8'h00);
    rd_chk(bcr_pkg::IDX_B1_LIMIT, 8'h01);
    wr_reg(bcr_pkg::IDX_B2_RUN, 8'h0a);
    wait_code(6'h0a, n);
    chk(32'(n >= 380 && n <= 420), 32'h1);
    $display("Test fuse_override done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    t_fuse_defaults();
    t_voltage_codes();
    t_limit_decode();
    t_discharge();
    t_modes();
    t_ramp();
    t_clock_enable();
    t_fuse_override();
    wrap_up();
  end
endmodule
